// File: core/vasfe_map.vh
// Constants for the voice activity spectral front end
`ifndef VASFE_MAP_VH
`define VASFE_MAP_VH
// Register byte offsets
`define VASFE_CTRL_OFF     8'h00
`define VASFE_STATUS_OFF   8'h04
`define VASFE_ENERGY_OFF   8'h08
`define VASFE_THRESH_OFF   8'h0c
`define VASFE_DIST_OFF     8'h10
`define VASFE_FRAMES_OFF   8'h14
// Control fields
`define VASFE_CTRL_EN_BIT   0
`define VASFE_CTRL_TONE_BIT 1
`define VASFE_CTRL_RESET    32'h0000_0001
// Status fields
`define VASFE_ST_SPEECH_BIT 0
`define VASFE_ST_RAW_BIT    1
`define VASFE_ST_STAT_BIT   2
`define VASFE_ST_PTCH_BIT   3
`define VASFE_ST_BUSY_BIT   4
// Frame timing and fixed point
`define VASFE_FRAME_MS      20
`define VASFE_ORDER         8
`define VASFE_AVG_FRAMES    4
`define VASFE_Q_SHIFT       14
`define VASFE_Q_ONE         64'sd16384
`define VASFE_RVAD_SHIFT    11
// Spectral comparison: 0.05 in Q14
`define VASFE_DM_THRESH     64'sd819
`define VASFE_DM_RESET      64'sd0
// Threshold adaptation
`define VASFE_PTH           64'sd300000
`define VASFE_PLEV          64'sd800000
`define VASFE_FAC           64'sd3
`define VASFE_ADP           4'd8
`define VASFE_INC_SHIFT     4
`define VASFE_DEC_SHIFT     5
`define VASFE_MARGIN        64'sd80000000
`define VASFE_THVAD_RESET   64'sd1000000
`define VASFE_RVAD0_RESET   64'sd6
`define VASFE_RVAD1_RESET   -64'sd4
`define VASFE_RVAD2_RESET   64'sd1
// Periodicity
`define VASFE_LTHRESH       7'd2
`define VASFE_NTHRESH       4'd4
`define VASFE_LAG_RESET     7'd40
`endif

// File: core/vasfe_core.v
// Voice activity spectral front end with its AHB-Lite register slave
//
// Summary of operation
// - One speech-present flag is produced for each 20 ms encoder frame.
// - Filtered energy is rvad0*acf0 plus twice products for indices 1..8.
// - Recent sum covers last four frames; delayed sum is recent sum four frames earlier.
// - Eight predictor coefficients solve Toeplitz equations of delayed sum; coefficient zero is -1.
// - Candidate autocorrelated value i is sum of coefficient k times coefficient k+i.
// - Distortion is weighted candidate-recent product over recent sum index zero.
// - Stationary when distortion change is below 0.05; stored distortion starts at zero.
// - Speech is declared when filtered energy exceeds the adaptive threshold.
// - Threshold and filter adapt only when stationary, unpitched and tone free.
// - A fixed low-level threshold keeps quiet non-stationary noise out of speech.
// - Hangover extends the decision only after bursts of minimum length.
// - Raw decision is true exactly when energy is strictly above threshold.
// - Periodicity flag is set when the sum of the previous two lag counts reaches the limit.
`timescale 1ns/100ps
`default_nettype none
`include "vasfe_map.vh"
module vasfe_core #(
  parameter ACF_W = 32,
  parameter LAG_W = 7,
  parameter BURST_CONST = 3,
  parameter HANG_CONST = 5
) (
  input wire sys_clk, // System clock, 50 MHz
  input wire reset_n, // Asynchronous reset, active low
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response
  output reg [31:0] hrdata, // AHB read data
  input wire frame_valid, // Frame strobe from encoder
  input wire [9*ACF_W-1:0] acf_flat, // Frame autocorrelations 0..8
  input wire [4*LAG_W-1:0] lag_flat, // Long-term lags of four sub-segments
  output reg speech_flag, // Decision with hangover
  output reg stationary_flag, // Spectral stationarity
  output reg periodic_flag, // Periodicity
  output reg frame_done // One-cycle pulse per processed frame
);
  localparam S_IDLE = 3'd0;
  localparam S_LEV = 3'd1;
  localparam S_DIV = 3'd2;
  localparam S_LUPD = 3'd3;
  localparam S_RAV = 3'd4;
  localparam S_DEC = 3'd5;
  localparam R_LEV = 1'b0;
  localparam R_DM = 1'b1;
  localparam HANG_LOAD = HANG_CONST - 1;

  // ***************************************************
  // Helpers
  // ***************************************************
  function signed [63:0] energy9;
    input [575:0] a;
    input [575:0] b;
    integer i;
    reg signed [63:0] s;
    begin
      s = $signed(a[63:0]) * $signed(b[63:0]);
      for (i = 1; i < 9; i = i + 1) begin
        s = s + (($signed(a[i*64 +: 64]) * $signed(b[i*64 +: 64])) <<< 1);
      end
      energy9 = s;
    end
  endfunction

  function [63:0] mag;
    input signed [63:0] v;
    begin
      mag = v[63] ? -v : v;
    end
  endfunction

  function lag_hit;
    input [LAG_W-1:0] a;
    input [LAG_W-1:0] b;
    reg [LAG_W-1:0] mx;
    reg [LAG_W-1:0] mn;
    reg [LAG_W-1:0] sm;
    begin
      mx = (a > b) ? a : b;
      mn = (a > b) ? b : a;
      sm = (mn == {LAG_W{1'b0}}) ? {LAG_W{1'b0}} : mx % mn;
      lag_hit = (mn != {LAG_W{1'b0}}) && (((sm < mn - sm) ? sm : mn - sm) < `VASFE_LTHRESH);
    end
  endfunction

  // ***************************************************
  // State
  // ***************************************************
  reg [2:0] state;
  reg div_ret;
  reg enable;
  reg tone_flag;
  reg [31:0] frame_count;
  reg signed [63:0] acf_hist [0:35];
  reg signed [63:0] av0_hist [0:35];
  reg [1:0] wp;
  reg [575:0] acf_q;
  reg [575:0] recent_acf_sum;
  reg [575:0] delayed_acf_sum;
  reg [575:0] candidate_predictor_coeffs;
  reg [575:0] candidate_predictor_autocorr;
  reg [575:0] rvad;
  reg signed [63:0] lev_err;
  reg signed [63:0] lev_acc;
  reg [3:0] lev_m;
  reg signed [63:0] pvad;
  reg signed [63:0] thvad;
  reg signed [63:0] spectral_distortion;
  reg signed [63:0] last_dm;
  reg [3:0] adapt_count;
  reg [7:0] burst_count;
  reg signed [7:0] hang_count;
  reg raw_decision;
  reg [2:0] old_lag_count;
  reg [2:0] very_old_lag_count;
  reg [LAG_W-1:0] prev_lag;
  reg [LAG_W-1:0] lag_q [0:3];
  reg [63:0] div_rem;
  reg [63:0] div_quo;
  reg [63:0] div_den;
  reg [6:0] div_cnt;
  reg div_neg;
  reg a_phase;
  reg a_write;
  reg [7:0] a_addr;

  // ***************************************************
  // Combinational arithmetic
  // ***************************************************
  reg signed [63:0] next_acc;
  reg [575:0] next_rav;
  reg signed [63:0] prod;
  reg [63:0] div_tmp;
  reg signed [63:0] div_res;
  reg signed [63:0] km;
  reg signed [63:0] next_thvad;
  reg signed [63:0] pvad3;
  reg signed [63:0] t_dec;
  reg signed [63:0] t_inc;
  reg stat_now;
  reg quiet_now;
  reg adapt_ok;
  reg [2:0] lag_count;
  integer k;
  integer j;
  // Own loop index so the clocked engine's k has a single driver
  integer c;

  always @* begin
    next_acc = 64'sd0;
    next_rav = {576{1'b0}};
    prod = 64'sd0;
    next_acc = $signed(delayed_acf_sum[lev_m*64 +: 64]) * `VASFE_Q_ONE;
    for (c = 1; c < 8; c = c + 1) begin
      if (c < lev_m) begin
        next_acc = next_acc - $signed(candidate_predictor_coeffs[c*64 +: 64])
                   * $signed(delayed_acf_sum[(lev_m-c)*64 +: 64]);
      end
    end
    for (j = 0; j < 9; j = j + 1) begin
      prod = 64'sd0;
      for (c = 0; c < 9; c = c + 1) begin
        if (c + j < 9) begin
          prod = prod + $signed(candidate_predictor_coeffs[c*64 +: 64])
                 * $signed(candidate_predictor_coeffs[(c+j)*64 +: 64]);
        end
      end
      next_rav[j*64 +: 64] = prod >>> `VASFE_Q_SHIFT;
    end
  end

  always @* begin
    div_tmp = {div_rem[62:0], div_quo[63]};
    div_res = div_neg ? -$signed(div_quo) : $signed(div_quo);
    km = div_res;
    if (km >= `VASFE_Q_ONE) begin
      km = `VASFE_Q_ONE - 64'sd1;
    end
    if (km <= -`VASFE_Q_ONE) begin
      km = 64'sd1 - `VASFE_Q_ONE;
    end
  end

  always @* begin
    stat_now = mag(spectral_distortion - last_dm) < `VASFE_DM_THRESH;
    quiet_now = $signed(acf_q[63:0]) < `VASFE_PTH;
    adapt_ok = stat_now && !periodic_flag && !tone_flag;
    pvad3 = pvad * `VASFE_FAC;
    t_dec = thvad - (thvad >>> `VASFE_DEC_SHIFT);
    t_inc = thvad + (thvad >>> `VASFE_INC_SHIFT);
    if (t_dec >= pvad3) begin
      next_thvad = t_dec;
    end else if (pvad3 > t_inc) begin
      next_thvad = t_inc;
    end else begin
      next_thvad = pvad3;
    end
    if (next_thvad > pvad + `VASFE_MARGIN) begin
      next_thvad = pvad + `VASFE_MARGIN;
    end
    lag_count = {2'b00, lag_hit(lag_q[0], prev_lag)} + {2'b00, lag_hit(lag_q[1], lag_q[0])}
                + {2'b00, lag_hit(lag_q[2], lag_q[1])} + {2'b00, lag_hit(lag_q[3], lag_q[2])};
  end

  // ***************************************************
  // Frame engine
  // ***************************************************
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      div_ret <= R_LEV;
      wp <= 2'd0;
      for (k = 0; k < 36; k = k + 1) begin
        acf_hist[k] <= 64'sd0;
        av0_hist[k] <= 64'sd0;
      end
      for (k = 0; k < 4; k = k + 1) begin
        lag_q[k] <= `VASFE_LAG_RESET;
      end
      acf_q <= {576{1'b0}};
      recent_acf_sum <= {576{1'b0}};
      delayed_acf_sum <= {576{1'b0}};
      candidate_predictor_coeffs <= {576{1'b0}};
      candidate_predictor_autocorr <= {576{1'b0}};
      rvad <= {{384{1'b0}}, `VASFE_RVAD2_RESET, `VASFE_RVAD1_RESET, `VASFE_RVAD0_RESET};
      lev_err <= 64'sd0;
      lev_acc <= 64'sd0;
      lev_m <= 4'd1;
      pvad <= 64'sd0;
      thvad <= `VASFE_THVAD_RESET;
      spectral_distortion <= `VASFE_DM_RESET;
      last_dm <= `VASFE_DM_RESET;
      adapt_count <= 4'd0;
      burst_count <= 8'd0;
      hang_count <= -8'sd1;
      raw_decision <= 1'b0;
      old_lag_count <= 3'd0;
      very_old_lag_count <= 3'd0;
      prev_lag <= `VASFE_LAG_RESET;
      div_rem <= 64'd0;
      div_quo <= 64'd0;
      div_den <= 64'd0;
      div_cnt <= 7'd0;
      div_neg <= 1'b0;
      speech_flag <= 1'b0;
      stationary_flag <= 1'b0;
      periodic_flag <= 1'b0;
      frame_done <= 1'b0;
      frame_count <= 32'h0000_0000;
    end else begin
      frame_done <= 1'b0;
      case (state)
        S_IDLE: begin
          // history moves once per accepted strobe
          if (frame_valid && enable) begin
            for (k = 0; k < 9; k = k + 1) begin
              acf_q[k*64 +: 64] <= {{(64-ACF_W){acf_flat[k*ACF_W+ACF_W-1]}}, acf_flat[k*ACF_W +: ACF_W]};
              // running four-frame sum and four-frame delay
              recent_acf_sum[k*64 +: 64] <= $signed(recent_acf_sum[k*64 +: 64]) - acf_hist[wp*9+k]
                + $signed({{(64-ACF_W){acf_flat[k*ACF_W+ACF_W-1]}}, acf_flat[k*ACF_W +: ACF_W]});
              delayed_acf_sum[k*64 +: 64] <= av0_hist[wp*9+k];
              acf_hist[wp*9+k] <= $signed({{(64-ACF_W){acf_flat[k*ACF_W+ACF_W-1]}}, acf_flat[k*ACF_W +: ACF_W]});
              av0_hist[wp*9+k] <= $signed(recent_acf_sum[k*64 +: 64]) - acf_hist[wp*9+k]
                + $signed({{(64-ACF_W){acf_flat[k*ACF_W+ACF_W-1]}}, acf_flat[k*ACF_W +: ACF_W]});
            end
            for (k = 0; k < 4; k = k + 1) begin
              lag_q[k] <= lag_flat[k*LAG_W +: LAG_W];
            end
            // coefficient zero fixed at minus one
            candidate_predictor_coeffs <= {{512{1'b0}}, -`VASFE_Q_ONE};
            lev_m <= 4'd1;
            state <= S_LEV;
          end
        end
        S_LEV: begin
          lev_err <= (lev_m == 4'd1) ? $signed(delayed_acf_sum[63:0]) : lev_err;
          lev_acc <= next_acc;
          if ((lev_m == 4'd1 && $signed(delayed_acf_sum[63:0]) <= 64'sd0) ||
              (lev_m != 4'd1 && lev_err <= 64'sd0)) begin
            // Singular history: keep the orders solved so far
            state <= S_RAV;
          end else begin
            div_rem <= 64'd0;
            div_quo <= mag(next_acc);
            div_den <= (lev_m == 4'd1) ? mag($signed(delayed_acf_sum[63:0])) : mag(lev_err);
            div_neg <= next_acc[63];
            div_cnt <= 7'd64;
            div_ret <= R_LEV;
            state <= S_DIV;
          end
        end
        S_DIV: begin
          // Serial restoring divider, shared by both quotients
          if (div_cnt == 7'd0) begin
            state <= (div_ret == R_LEV) ? S_LUPD : S_DEC;
            if (div_ret == R_DM) begin
              spectral_distortion <= div_res;
            end
          end else begin
            div_cnt <= div_cnt - 7'd1;
            if (div_tmp >= div_den) begin
              div_rem <= div_tmp - div_den;
              div_quo <= {div_quo[62:0], 1'b1};
            end else begin
              div_rem <= div_tmp;
              div_quo <= {div_quo[62:0], 1'b0};
            end
          end
        end
        S_LUPD: begin
          // Levinson step on the delayed sum
          candidate_predictor_coeffs[lev_m*64 +: 64] <= km;
          for (k = 1; k < 8; k = k + 1) begin
            if (k < lev_m) begin
              candidate_predictor_coeffs[k*64 +: 64] <= $signed(candidate_predictor_coeffs[k*64 +: 64])
                - ((km * $signed(candidate_predictor_coeffs[(lev_m-k)*64 +: 64])) >>> `VASFE_Q_SHIFT);
            end
          end
          lev_err <= lev_err - ((km * lev_acc) >>> (2 * `VASFE_Q_SHIFT));
          lev_m <= lev_m + 4'd1;
          state <= (lev_m == `VASFE_ORDER) ? S_RAV : S_LEV;
        end
        S_RAV: begin
          candidate_predictor_autocorr <= next_rav;
          pvad <= energy9(rvad, acf_q);
          // distortion numerator over recent sum zero
          div_rem <= 64'd0;
          div_quo <= mag(energy9(next_rav, recent_acf_sum));
          div_den <= mag($signed(recent_acf_sum[63:0]));
          div_neg <= energy9(next_rav, recent_acf_sum) < 64'sd0;
          div_cnt <= 7'd64;
          div_ret <= R_DM;
          if ($signed(recent_acf_sum[63:0]) == 64'sd0) begin
            spectral_distortion <= 64'sd0;
            state <= S_DEC;
          end else begin
            state <= S_DIV;
          end
        end
        S_DEC: begin
          stationary_flag <= stat_now;
          last_dm <= spectral_distortion;
          raw_decision <= pvad > thvad;
          // hangover only after a full burst
          if (pvad > thvad) begin
            if (burst_count + 8'd1 >= BURST_CONST) begin
              burst_count <= BURST_CONST[7:0];
              hang_count <= HANG_LOAD[7:0];
            end else begin
              burst_count <= burst_count + 8'd1;
              hang_count <= (hang_count >= 0) ? hang_count - 8'sd1 : hang_count;
            end
          end else begin
            burst_count <= 8'd0;
            hang_count <= (hang_count >= 0) ? hang_count - 8'sd1 : hang_count;
          end
          speech_flag <= (pvad > thvad) || (pvad > thvad && burst_count + 8'd1 >= BURST_CONST) ||
                         (hang_count >= 0);
          if (quiet_now) begin
            thvad <= `VASFE_PLEV;
          end else if (adapt_ok) begin
            if (adapt_count + 4'd1 >= `VASFE_ADP) begin
              adapt_count <= `VASFE_ADP;
              thvad <= next_thvad;
              for (k = 0; k < 9; k = k + 1) begin
                rvad[k*64 +: 64] <= $signed(next_rav[k*64 +: 64]) >>> `VASFE_RVAD_SHIFT;
              end
            end else begin
              adapt_count <= adapt_count + 4'd1;
            end
          end else begin
            adapt_count <= 4'd0;
          end
          // periodicity from the two previous frames, then age counts
          periodic_flag <= ({1'b0, old_lag_count} + {1'b0, very_old_lag_count}) >= `VASFE_NTHRESH;
          very_old_lag_count <= old_lag_count;
          old_lag_count <= lag_count;
          prev_lag <= lag_q[3];
          wp <= wp + 2'd1;
          frame_count <= frame_count + 32'h0000_0001;
          frame_done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      if (a_phase && a_write && a_addr == `VASFE_THRESH_OFF && state != S_DEC) begin
        thvad <= {32'h0000_0000, hwdata};
      end
    end
  end

  // ***************************************************
  // AHB-Lite slave, zero wait states
  // ***************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      a_phase <= 1'b0;
      a_write <= 1'b0;
      a_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      enable <= 1'b1;
      tone_flag <= 1'b0;
    end else begin
      if (a_phase && a_write && a_addr == `VASFE_CTRL_OFF) begin
        enable <= hwdata[`VASFE_CTRL_EN_BIT];
        tone_flag <= hwdata[`VASFE_CTRL_TONE_BIT];
      end
      a_phase <= hsel && htrans[1] && hready;
      a_write <= hwrite;
      a_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[7:0])
          `VASFE_CTRL_OFF: hrdata <= {30'h0, tone_flag, enable};
          `VASFE_STATUS_OFF: hrdata <= {27'h0, state != S_IDLE, periodic_flag, stationary_flag,
                                        raw_decision, speech_flag};
          `VASFE_ENERGY_OFF: hrdata <= pvad[31:0];
          `VASFE_THRESH_OFF: hrdata <= thvad[31:0];
          `VASFE_DIST_OFF: hrdata <= spectral_distortion[31:0];
          `VASFE_FRAMES_OFF: hrdata <= frame_count;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/vasfe_core_properties.sv
// Port-level assertions for the spectral front end
`timescale 1ns/100ps
`default_nettype none
module vasfe_core_properties (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata, // Read data
  input wire logic frame_valid, // Frame strobe
  input wire logic speech_flag, // Decision
  input wire logic stationary_flag, // Stationarity
  input wire logic periodic_flag, // Periodicity
  input wire logic frame_done // Frame pulse
);
  // ****************
  // Helper state
  // ****************
  logic strobe_seen;
  wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
  // Ignored strobes arm it too, so this only catches spontaneous results
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_seen <= 1'b0;
    end else if (frame_valid) begin
      strobe_seen <= 1'b1;
    end else if (frame_done) begin
      strobe_seen <= 1'b0;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_done;
    frame_done;
  endsequence
  sequence s_quiet;
    !frame_done;
  endsequence
  property p_done_pulse;
    s_done |=> s_quiet;
  endproperty
  property p_done_cause;
    s_done |-> strobe_seen;
  endproperty
  property p_speech_hold;
    !frame_done |-> $stable(speech_flag);
  endproperty
  property p_stat_hold;
    !frame_done |-> $stable(stationary_flag);
  endproperty
  property p_per_hold;
    !frame_done |-> $stable(periodic_flag);
  endproperty
  property p_rdata_hold;
    !$stable(hrdata) |-> $past(rd_take);
  endproperty
  property p_ready;
    hreadyout;
  endproperty
  property p_okay;
    !hresp;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("frame_done longer than a cycle");
  a_done_cause: assert property (p_done_cause) else $error("frame_done without strobe");
  a_speech_hold: assert property (p_speech_hold) else $error("speech_flag moved between frames");
  a_stat_hold: assert property (p_stat_hold) else $error("stationary_flag moved between frames");
  a_per_hold: assert property (p_per_hold) else $error("periodic_flag moved between frames");
  a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved without a read");
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
endmodule
`default_nettype wire

// File: verif/vasfe_encoder_model.sv
// Speech encoder model handing over one frame of analysis results
`timescale 1ns/100ps
`default_nettype none
module vasfe_encoder_model (
  input wire logic sys_clk, // Clock
  output logic frame_valid, // Frame strobe
  output logic [287:0] acf_flat, // Autocorrelations 0..8
  output logic [27:0] lag_flat // Lags N0..N3
);
  initial begin
    frame_valid = 1'b0;
    acf_flat = 288'h0;
    lag_flat = 28'h0;
  end
  task automatic send(input logic [31:0] a0, a1, a2, input logic pitched);
    @(posedge sys_clk);
    frame_valid <= 1'b1;
    acf_flat <= {192'h0, a2, a1, a0};
    // Equal lags give four near-multiples; 57 against 40 gives none
    lag_flat <= pitched ? {4{7'h28}} : {7'h28, 7'h39, 7'h28, 7'h39};
    @(posedge sys_clk);
    frame_valid <= 1'b0;
    // Stale data must not look valid once the strobe is gone
    acf_flat <= ~acf_flat;
    lag_flat <= ~lag_flat;
  endtask
endmodule
`default_nettype wire

// File: verif/voice_activity_spectral_front_end_test.sv
// Self-checking bench for the voice activity spectral front end
`timescale 1ns/100ps
`default_nettype none
`include "vasfe_map.vh"
module voice_activity_spectral_front_end_test;
  // ****************
  // Signals and frame table
  // ****************
  typedef struct packed {
    logic [31:0] a0;
    logic [31:0] a1;
    logic [31:0] a2;
    logic pitched;
    logic raw;
    logic speech;
    logic per;
    logic [1:0] stat;
  } vasfe_row_t;
  localparam int NROWS = 11;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic frame_valid;
  wire logic [287:0] acf_flat;
  wire logic [27:0] lag_flat;
  wire logic speech_flag;
  wire logic stationary_flag;
  wire logic periodic_flag;
  wire logic frame_done;
  int miscompares = 0;
  int n_checks = 0;
  int k;
  logic [31:0] rd;
  logic [31:0] f0;
  // Stat 2: not worked out; a three-frame burst then five frames of hangover
  vasfe_row_t rows [NROWS] = '{
    '{32'h61a80, 32'h186a0, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0},
    '{32'h61a80, 32'h30d40, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1},
    '{32'h7a120, 32'h0, 32'h0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h1},
    '{32'h7a120, 32'hc350, 32'h186a0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h1},
    '{32'h493e0, 32'h0, 32'h0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h2},
    '{32'h493e0, 32'h186a0, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2},
    '{32'h493e0, 32'h493e0, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2},
    '{32'h493e0, 32'h493e0, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2},
    '{32'h493e0, 32'h493e0, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2},
    '{32'h493e0, 32'h493e0, 32'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h2},
    '{32'h493e0, 32'h493e0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2}
  };
  always #10 sys_clk = ~sys_clk;
  vasfe_core u_vasfe_core (
    .sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frame_valid, .acf_flat, .lag_flat,
    .speech_flag, .stationary_flag, .periodic_flag, .frame_done
  );
  vasfe_encoder_model u_vasfe_encoder_model (.sys_clk, .frame_valid, .acf_flat, .lag_flat);
  // ****************
  // Tasks
  // ****************
  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdata);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, rd);
    check32(rd, exp, what);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 1000 && frame_done !== 1'b1; i++) @(negedge sys_clk);
    check1(frame_done, 1'b1, "frame_done");
  endtask
  task automatic count_dones(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (frame_done === 1'b1) c++;
    end
  endtask
  // Filter stays at its reset taps 6, -4, 1 while tone is flagged
  task automatic run_frame(input vasfe_row_t r);
    logic [63:0] e;
    e = 64'h6 * r.a0 - 64'h8 * r.a1 + 64'h2 * r.a2;
    u_vasfe_encoder_model.send(r.a0, r.a1, r.a2, r.pitched);
    wait_done;
    check1(speech_flag, r.speech, "speech");
    check1(periodic_flag, r.per, "periodic");
    if (r.stat != 2'h2) check1(stationary_flag, r.stat[0], "stationary");
    bus(1'b0, `VASFE_STATUS_OFF, 32'h0, rd);
    check1(rd[`VASFE_ST_RAW_BIT], r.raw, "raw");
    check1(rd[`VASFE_ST_SPEECH_BIT], r.speech, "status speech");
    rchk(`VASFE_ENERGY_OFF, e[31:0], "energy");
  endtask
  task automatic end_test(input string name);
    $display("test %s over, mismatches %0d", name, miscompares);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  // Some 15 processed frames of under 700 cycles plus two idle windows
  initial begin
    #1000000;
    miscompares++;
    $display("[ERR] %0t watchdog", $time);
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    rchk(`VASFE_CTRL_OFF, 32'h1, "ctrl");
    rchk(`VASFE_THRESH_OFF, 32'hf4240, "threshold");
    rchk(`VASFE_DIST_OFF, 32'h0, "distortion");
    rchk(`VASFE_FRAMES_OFF, 32'h0, "frames");
    rchk(8'h20, 32'h0, "unmapped");
    bus(1'b1, `VASFE_CTRL_OFF, 32'h3, rd);
    rchk(`VASFE_CTRL_OFF, 32'h3, "ctrl write");
    end_test("registers");
    for (int i = 0; i < NROWS; i++) begin
      run_frame(rows[i]);
      rchk(`VASFE_FRAMES_OFF, 32'(i + 1), "frame count");
      // Empty delayed sum leaves only the -1 tap, so distortion is one
      if (i < 4) rchk(`VASFE_DIST_OFF, 32'h4000, "unit distortion");
    end
    end_test("table");
    run_frame('{32'h186a0, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2});
    rchk(`VASFE_THRESH_OFF, 32'hc3500, "low level");
    bus(1'b1, `VASFE_THRESH_OFF, 32'h1e8480, rd);
    run_frame('{32'h61a80, 32'h186a0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2});
    rchk(`VASFE_THRESH_OFF, 32'h1e8480, "no adapt");
    run_frame('{32'h7a120, 32'h0, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h2});
    end_test("threshold");
    bus(1'b0, `VASFE_FRAMES_OFF, 32'h0, f0);
    u_vasfe_encoder_model.send(32'h7a120, 32'h0, 32'h0, 1'b0);
    fork
      count_dones(1400, k);
      begin
        repeat (3) @(posedge sys_clk);
        u_vasfe_encoder_model.send(32'h61a80, 32'h0, 32'h0, 1'b0);
      end
    join
    check32(32'(k), 32'h1, "busy strobe");
    bus(1'b1, `VASFE_CTRL_OFF, 32'h2, rd);
    u_vasfe_encoder_model.send(32'h7a120, 32'h0, 32'h0, 1'b0);
    count_dones(1400, k);
    check32(32'(k), 32'h0, "disabled strobe");
    rchk(`VASFE_FRAMES_OFF, f0 + 32'h1, "frame count");
    bus(1'b1, `VASFE_CTRL_OFF, 32'h3, rd);
    bus(1'b0, `VASFE_ENERGY_OFF, 32'h0, f0);
    bus(1'b1, `VASFE_ENERGY_OFF, 32'h0, rd);
    rchk(`VASFE_ENERGY_OFF, f0, "energy read only");
    end_test("refusals");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(negedge sys_clk);
    check1(speech_flag, 1'b0, "speech in reset");
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    rchk(`VASFE_FRAMES_OFF, 32'h0, "frames");
    rchk(`VASFE_THRESH_OFF, 32'hf4240, "threshold");
    end_test("second reset");
    give_verdict;
  end
endmodule
bind vasfe_core vasfe_core_properties u_vasfe_core_properties (
  .sys_clk, .reset_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .frame_valid, .speech_flag, .stationary_flag, .periodic_flag, .frame_done
);
`default_nettype wire
